// file: fsp_defines.svh
// Overview of operation
// - Flash erases whole or per sector, and programs one byte at a time with external supply.
// - Erasing or programming one sector never changes any other sector.
// - Through the external tool every sector and the option byte may be changed.
// - Self-programming requests that hit sector 0 are refused.
// - Sector count follows array size: 4K one, 8K two, larger three.
// - Sectors 0 and 1 are 4 Kbytes at the top; the rest is sector 2.
// - Sector 0 decodes the topmost range holding the vectors.
// - Read-out protection blocks content extraction and all flash writes.
// - Removing protection first erases the whole array automatically.
// - Protection follows only the protection bit of the option byte.
// - Low-voltage supervisor is unavailable while protection is on.
// - A key sequence must arm the CPU path before any program or erase.
// - Link uses serial clock, two-way serial data and voltage select pins.
// - Tool can load test patterns into RAM and start their execution.
`ifndef FSP_DEFINES_SVH
`define FSP_DEFINES_SVH
`define FSP_ARRAY_KB 16
`define FSP_IDX_W 14
`define FSP_ARRAY_BASE 16'hc000
`define FSP_SEC0_BASE 16'hf000
`define FSP_SEC1_BASE 16'he000
`define FSP_SEC0_LO 14'h3000
`define FSP_SEC0_HI 14'h3fff
`define FSP_SEC1_LO 14'h2000
`define FSP_SEC1_HI 14'h2fff
`define FSP_SEC2_LO 14'h0000
`define FSP_SEC2_HI 14'h1fff
`define FSP_ERASED 8'hff
`define FSP_KEY1 8'h56
`define FSP_KEY2 8'hae
`define FSP_FRAME_LAST 6'd31
`define FSP_TX_BITS 4'd8
`define FSP_TRAM_WORDS 64
`endif

// file: fsp_pkg.sv
package fsp_pkg;
    typedef enum logic [1:0] {FSP_IDLE = 2'b00, FSP_ERASE = 2'b01, FSP_UNLOCK = 2'b11} fsp_state_t;
    typedef enum logic [1:0] {FSP_OP_PROG = 2'b00, FSP_OP_SECT = 2'b01, FSP_OP_MASS = 2'b10} fsp_op_t;
    typedef enum logic [7:0] {
        FSP_CMD_PROG = 8'h01, FSP_CMD_SECT = 8'h02, FSP_CMD_MASS = 8'h03, FSP_CMD_READ = 8'h04,
        FSP_CMD_OPT = 8'h05, FSP_CMD_TRAM = 8'h06, FSP_CMD_EXEC = 8'h07
    } fsp_cmd_t;
endpackage : fsp_pkg

// file: fsp_icc_link.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defines.svh"
module fsp_icc_link import fsp_pkg::*; (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_srst,
    // Link pins
    input wire logic i_clk_pin,
    input wire logic i_data_pin,
    output logic o_data_pin,
    output logic o_data_oe,
    // Session and reply
    input wire logic i_active,
    input wire logic i_rd_load,
    input wire logic [7:0] i_rd_byte,
    // Received frame
    output logic o_frame_vld,
    output logic [7:0] o_cmd,
    output logic [15:0] o_addr,
    output logic [7:0] o_data
);
    logic ck_s1_r, ck_s2_r, ck_s3_r, dt_s1_r, dt_s2_r;
    logic [30:0] sh_r, sh_nxt;
    logic [5:0] cnt_r, cnt_nxt;
    logic [7:0] tx_r, tx_nxt;
    logic [3:0] txc_r, txc_nxt;
    logic oe_r, oe_nxt, vld_r, vld_nxt;
    logic [31:0] frm_r, frm_nxt;
    logic rise, fall;

    assign rise = ck_s2_r & ~ck_s3_r;
    assign fall = ~ck_s2_r & ck_s3_r;

    always_comb begin
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        tx_nxt = tx_r;
        txc_nxt = txc_r;
        oe_nxt = oe_r;
        vld_nxt = 1'b0;
        frm_nxt = frm_r;
        if (!i_active) begin
            cnt_nxt = 6'h00;
            txc_nxt = 4'h0;
            oe_nxt = 1'b0;
        end else if (i_rd_load) begin
            tx_nxt = i_rd_byte;
            txc_nxt = `FSP_TX_BITS;
            oe_nxt = 1'b1;
        end else if (txc_r != 4'h0) begin
            if (fall) begin
                tx_nxt = {tx_r[6:0], 1'b0};
                txc_nxt = txc_r - 4'h1;
                oe_nxt = (txc_r != 4'h1);
            end
        end else if (rise) begin
            sh_nxt = {sh_r[29:0], dt_s2_r};
            if (cnt_r == `FSP_FRAME_LAST) begin
                frm_nxt = {sh_r, dt_s2_r};
                vld_nxt = 1'b1;
                cnt_nxt = 6'h00;
            end else begin
                cnt_nxt = cnt_r + 6'h01;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        ck_s1_r <= i_clk_pin;
        ck_s2_r <= ck_s1_r;
        dt_s1_r <= i_data_pin;
        dt_s2_r <= dt_s1_r;
        if (i_srst) begin
            ck_s3_r <= 1'b0;
            sh_r <= 31'h00000000;
            cnt_r <= 6'h00;
            tx_r <= 8'h00;
            txc_r <= 4'h0;
            oe_r <= 1'b0;
            vld_r <= 1'b0;
            frm_r <= 32'h00000000;
        end else begin
            ck_s3_r <= ck_s2_r;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            tx_r <= tx_nxt;
            txc_r <= txc_nxt;
            oe_r <= oe_nxt;
            vld_r <= vld_nxt;
            frm_r <= frm_nxt;
        end
    end

    assign o_data_pin = tx_r[7];
    assign o_data_oe = oe_r;
    assign o_frame_vld = vld_r;
    assign o_cmd = frm_r[31:24];
    assign o_addr = frm_r[23:8];
    assign o_data = frm_r[7:0];

    chk_reply_drive: assert property (@(posedge i_clk) disable iff (i_srst)
        i_active && i_rd_load |=> o_data_oe && o_data_pin == $past(i_rd_byte[7])) else $error("reply not driven");
    chk_release_idle: assert property (@(posedge i_clk) disable iff (i_srst)
        !i_active |=> !o_data_oe) else $error("data pin driven outside session");
endmodule : fsp_icc_link
`default_nettype wire

// file: fsp_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defines.svh"
module fsp_ctrl import fsp_pkg::*; (
    // Clock and reset
    input wire logic I_CLK,
    input wire logic I_SRST,
    // Programming link pins
    input wire logic I_ICC_CLK,
    input wire logic I_ICC_DATA,
    output logic O_ICC_DATA,
    output logic O_ICC_DATA_OE,
    input wire logic I_VPP_SEL,
    // CPU flash port
    input wire logic I_CPU_KEY_WR,
    input wire logic [7:0] I_CPU_KEY,
    input wire logic I_CPU_REQ,
    input wire logic [1:0] I_CPU_OP,
    input wire logic [15:0] I_CPU_ADDR,
    input wire logic [7:0] I_CPU_WDATA,
    input wire logic I_CPU_RD,
    output logic [7:0] O_CPU_RDATA,
    // Status
    output logic O_BUSY,
    output logic O_DONE,
    output logic O_REJECT,
    output logic O_GUARD_ARMED,
    output logic O_PROTECTED,
    // Supervisor gate
    input wire logic I_LVD_REQ,
    output logic O_LVD_EN,
    // Test RAM
    input wire logic [5:0] I_TRAM_ADDR,
    output logic [7:0] O_TRAM_DATA,
    output logic O_TEST_RUN,
    output logic [15:0] O_TEST_ENTRY
);
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [1:0] sector_of(input logic [15:0] a);
        if (a >= `FSP_SEC0_BASE || `FSP_ARRAY_KB <= 4) sector_of = 2'd0;
        else if (a >= `FSP_SEC1_BASE || `FSP_ARRAY_KB <= 8) sector_of = 2'd1;
        else sector_of = 2'd2;
    endfunction : sector_of

    function automatic logic [13:0] sec_lo(input logic [1:0] s);
        sec_lo = (s == 2'd0) ? `FSP_SEC0_LO : (s == 2'd1) ? `FSP_SEC1_LO : `FSP_SEC2_LO;
    endfunction : sec_lo

    function automatic logic [13:0] sec_hi(input logic [1:0] s);
        sec_hi = (s == 2'd0) ? `FSP_SEC0_HI : (s == 2'd1) ? `FSP_SEC1_HI : `FSP_SEC2_HI;
    endfunction : sec_hi

    function automatic logic [13:0] idx_of(input logic [15:0] a);
        logic [15:0] d;
        d = a - `FSP_ARRAY_BASE;
        idx_of = d[13:0];
    endfunction : idx_of

    ////////////////////////////////////////////////////////////////////////////////
    logic [7:0] mem [0:(1 << `FSP_IDX_W) - 1];
    logic [7:0] tram [0:`FSP_TRAM_WORDS - 1];
    logic vpp_s1_r, vpp_s2_r;
    logic frm_vld, rd_load_r, rd_load_nxt;
    logic [7:0] frm_cmd, frm_data, rd_byte_r, rd_byte_nxt;
    logic [15:0] frm_addr;
    fsp_state_t state_r, state_nxt;
    logic [13:0] cur_r, cur_nxt, end_r, end_nxt;
    logic unprot_r, unprot_nxt, prot_r, prot_nxt, armed_r, armed_nxt, key1_r, key1_nxt;
    logic done_r, done_nxt, rej_r, rej_nxt;
    logic mem_we, tram_we, run_r, run_nxt;
    logic [13:0] mem_wa;
    logic [7:0] mem_wd, cpu_rd_r, tram_rd_r;
    logic [15:0] entry_r, entry_nxt;
    logic tool_op, tool_arr;

    fsp_icc_link u_link (
        .i_clk(I_CLK),
        .i_srst(I_SRST),
        .i_clk_pin(I_ICC_CLK),
        .i_data_pin(I_ICC_DATA),
        .o_data_pin(O_ICC_DATA),
        .o_data_oe(O_ICC_DATA_OE),
        .i_active(vpp_s2_r),
        .i_rd_load(rd_load_r),
        .i_rd_byte(rd_byte_r),
        .o_frame_vld(frm_vld),
        .o_cmd(frm_cmd),
        .o_addr(frm_addr),
        .o_data(frm_data)
    );

    assign tool_op = frm_vld && (frm_cmd == FSP_CMD_PROG || frm_cmd == FSP_CMD_SECT ||
                                 frm_cmd == FSP_CMD_MASS || frm_cmd == FSP_CMD_OPT);
    assign tool_arr = frm_addr >= `FSP_ARRAY_BASE;

    ////////////////////////////////////////////////////////////////////////////////
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        cur_nxt = cur_r;
        end_nxt = end_r;
        unprot_nxt = unprot_r;
        prot_nxt = prot_r;
        armed_nxt = armed_r;
        key1_nxt = key1_r;
        done_nxt = 1'b0;
        rej_nxt = 1'b0;
        mem_we = 1'b0;
        mem_wa = cur_r;
        mem_wd = `FSP_ERASED;
        if (I_CPU_KEY_WR) begin
            if (key1_r && I_CPU_KEY == `FSP_KEY2) begin
                armed_nxt = 1'b1;
                key1_nxt = 1'b0;
            end else begin
                armed_nxt = 1'b0;
                key1_nxt = (I_CPU_KEY == `FSP_KEY1);
            end
        end
        unique case (state_r)
            FSP_IDLE: begin
                if (tool_op) begin
                    if (!vpp_s2_r) begin
                        rej_nxt = 1'b1;
                    end else if (prot_r && !(frm_cmd == FSP_CMD_OPT && !frm_data[0])) begin
                        rej_nxt = 1'b1;
                    end else if (frm_cmd == FSP_CMD_OPT) begin
                        if (prot_r) begin
                            unprot_nxt = 1'b1;
                            cur_nxt = `FSP_SEC2_LO;
                            end_nxt = `FSP_SEC0_HI;
                            state_nxt = FSP_ERASE;
                        end else begin
                            prot_nxt = frm_data[0];
                            done_nxt = 1'b1;
                        end
                    end else if (frm_cmd == FSP_CMD_MASS) begin
                        cur_nxt = `FSP_SEC2_LO;
                        end_nxt = `FSP_SEC0_HI;
                        state_nxt = FSP_ERASE;
                    end else if (!tool_arr) begin
                        rej_nxt = 1'b1;
                    end else if (frm_cmd == FSP_CMD_SECT) begin
                        cur_nxt = sec_lo(sector_of(frm_addr));
                        end_nxt = sec_hi(sector_of(frm_addr));
                        state_nxt = FSP_ERASE;
                    end else begin
                        mem_we = 1'b1;
                        mem_wa = idx_of(frm_addr);
                        mem_wd = frm_data;
                        done_nxt = 1'b1;
                    end
                end else if (I_CPU_REQ) begin
                    armed_nxt = 1'b0;
                    if (!armed_r || !vpp_s2_r || prot_r || I_CPU_ADDR < `FSP_ARRAY_BASE) begin
                        rej_nxt = 1'b1;
                    end else if (sector_of(I_CPU_ADDR) == 2'd0 || I_CPU_OP == FSP_OP_MASS) begin
                        rej_nxt = 1'b1;
                    end else if (I_CPU_OP == FSP_OP_SECT) begin
                        cur_nxt = sec_lo(sector_of(I_CPU_ADDR));
                        end_nxt = sec_hi(sector_of(I_CPU_ADDR));
                        state_nxt = FSP_ERASE;
                    end else if (I_CPU_OP == FSP_OP_PROG) begin
                        mem_we = 1'b1;
                        mem_wa = idx_of(I_CPU_ADDR);
                        mem_wd = I_CPU_WDATA;
                        done_nxt = 1'b1;
                    end else begin
                        rej_nxt = 1'b1;
                    end
                end
            end
            FSP_ERASE: begin
                mem_we = 1'b1;
                cur_nxt = cur_r + 14'h0001;
                if (cur_r == end_r) begin
                    state_nxt = unprot_r ? FSP_UNLOCK : FSP_IDLE;
                    done_nxt = !unprot_r;
                end
                if (tool_op || I_CPU_REQ) rej_nxt = 1'b1;
            end
            FSP_UNLOCK: begin
                prot_nxt = 1'b0;
                unprot_nxt = 1'b0;
                done_nxt = 1'b1;
                state_nxt = FSP_IDLE;
                if (tool_op || I_CPU_REQ) rej_nxt = 1'b1;
            end
            default: state_nxt = FSP_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Tool read and test RAM
    always_comb begin
        rd_load_nxt = frm_vld && frm_cmd == FSP_CMD_READ;
        rd_byte_nxt = (prot_r || !tool_arr) ? 8'h00 : mem[idx_of(frm_addr)];
        tram_we = frm_vld && frm_cmd == FSP_CMD_TRAM && !prot_r;
        run_nxt = frm_vld && frm_cmd == FSP_CMD_EXEC && !prot_r;
        entry_nxt = run_nxt ? frm_addr : entry_r;
    end

    always_ff @(posedge I_CLK) begin
        vpp_s1_r <= I_VPP_SEL;
        vpp_s2_r <= vpp_s1_r;
        if (mem_we) mem[mem_wa] <= mem_wd;
        if (tram_we) tram[frm_addr[5:0]] <= frm_data;
        // Option bit is nonvolatile: survives reset
        prot_r <= prot_nxt;
        cpu_rd_r <= (I_CPU_RD && I_CPU_ADDR >= `FSP_ARRAY_BASE) ? mem[idx_of(I_CPU_ADDR)] : `FSP_ERASED;
        tram_rd_r <= tram[I_TRAM_ADDR];
        if (I_SRST) begin
            state_r <= FSP_IDLE;
            cur_r <= 14'h0000;
            end_r <= 14'h0000;
            unprot_r <= 1'b0;
            armed_r <= 1'b0;
            key1_r <= 1'b0;
            done_r <= 1'b0;
            rej_r <= 1'b0;
            rd_load_r <= 1'b0;
            rd_byte_r <= 8'h00;
            run_r <= 1'b0;
            entry_r <= 16'h0000;
        end else begin
            state_r <= state_nxt;
            cur_r <= cur_nxt;
            end_r <= end_nxt;
            unprot_r <= unprot_nxt;
            armed_r <= armed_nxt;
            key1_r <= key1_nxt;
            done_r <= done_nxt;
            rej_r <= rej_nxt;
            rd_load_r <= rd_load_nxt;
            rd_byte_r <= rd_byte_nxt;
            run_r <= run_nxt;
            entry_r <= entry_nxt;
        end
    end

    assign O_CPU_RDATA = cpu_rd_r;
    assign O_BUSY = state_r != FSP_IDLE;
    assign O_DONE = done_r;
    assign O_REJECT = rej_r;
    assign O_GUARD_ARMED = armed_r;
    assign O_PROTECTED = prot_r;
    assign O_LVD_EN = I_LVD_REQ && !prot_r;
    assign O_TRAM_DATA = tram_rd_r;
    assign O_TEST_RUN = run_r;
    assign O_TEST_ENTRY = entry_r;

    ////////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge I_CLK); endclocking
    default disable iff (I_SRST);
    sequence seq_unprot_req;
        state_r == FSP_IDLE && tool_op && vpp_s2_r && prot_r && frm_cmd == FSP_CMD_OPT && !frm_data[0];
    endsequence
    sequence seq_full_erase;
        state_r == FSP_ERASE && unprot_r && cur_r == `FSP_SEC2_LO && end_r == `FSP_SEC0_HI && prot_r;
    endsequence

    chk_unprot_erase: assert property (seq_unprot_req |=> seq_full_erase)
        else $error("unprotect did not start full erase");
    chk_prot_drop: assert property (!prot_r && $past(prot_r) |-> $past(state_r) == FSP_UNLOCK && done_r)
        else $error("protection dropped without erase");
    chk_sec0_self: assert property (state_r == FSP_IDLE && !tool_op && I_CPU_REQ &&
        sector_of(I_CPU_ADDR) == 2'd0 |=> O_REJECT && state_r == FSP_IDLE)
        else $error("self-programming reached sector 0");
    chk_no_supply: assert property (state_r == FSP_IDLE && !tool_op && I_CPU_REQ && !vpp_s2_r
        |=> O_REJECT && !O_DONE)
        else $error("request ran without supply");
    chk_guard_arm: assert property (I_CPU_REQ && !armed_r && !tool_op |=> O_REJECT && !O_BUSY)
        else $error("unarmed CPU request accepted");
    chk_prot_read: assert property (frm_vld && frm_cmd == FSP_CMD_READ && prot_r
        |=> rd_load_r && rd_byte_r == 8'h00)
        else $error("protected content leaked");
    chk_sec0_tool: assert property (state_r == FSP_IDLE && frm_vld && frm_cmd == FSP_CMD_SECT && vpp_s2_r &&
        !prot_r && frm_addr >= `FSP_SEC0_BASE |=> O_BUSY && cur_r == `FSP_SEC0_LO && end_r == `FSP_SEC0_HI)
        else $error("tool sector 0 erase refused");
    chk_erase_bound: assert property (mem_we && state_r == FSP_ERASE |-> cur_r >= sec_lo(2'd2) &&
        cur_r <= end_r ##1 cur_r == $past(cur_r) + 14'h0001 || state_r != FSP_ERASE)
        else $error("erase left its sector");
endmodule : fsp_ctrl
`default_nettype wire

// file: fsp_tool_model.sv
`timescale 1ns/1ns
`default_nettype none
module fsp_tool_model (
    // Device side of the link
    input wire logic i_dev_data,
    input wire logic i_dev_oe,
    // Tool side of the link
    output logic o_clk,
    output logic o_data,
    output logic o_vpp
);
    logic drv_r = 1'b0;
    logic own_r = 1'b0;

    initial begin
        o_clk = 1'b0;
        o_vpp = 1'b0;
    end

    // Wire level; a released line shows the inverse of its last value
    assign o_data = i_dev_oe ? i_dev_data : (own_r ? drv_r : ~drv_r);

    ////////////////////////////////////////////////////////////////////////////
    task automatic set_vpp(input logic v);
        o_vpp = v;
    endtask : set_vpp

    // MSB first, one bit per rising edge, 80 ns link period
    task automatic send_frame(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d, input logic hold);
        logic [31:0] f;
        f = {c, a, d};
        own_r = 1'b1;
        for (int i = 31; i >= 0; i--) begin
            o_clk = 1'b0;
            drv_r = f[i];
            #40 o_clk = 1'b1;
            #40;
        end
        own_r = 1'b0;
        if (!hold) o_clk = 1'b0;
    endtask : send_frame

    // First bit read while the last frame edge is still high
    task automatic get_reply(output logic [7:0] b);
        #200;
        b[7] = o_data;
        for (int i = 6; i >= 0; i--) begin
            o_clk = 1'b0;
            #40 o_clk = 1'b1;
            b[i] = o_data;
            #40;
        end
        o_clk = 1'b0;
        #100;
    endtask : get_reply
endmodule : fsp_tool_model
`default_nettype wire

// file: fsp_ctrl_test.sv
`timescale 1ns/1ns
`default_nettype none
`include "fsp_defines.svh"
module fsp_ctrl_test import fsp_pkg::*;;
    typedef struct packed {
        logic [1:0] arm;
        logic sup;
        logic [1:0] op;
        logic [15:0] addr;
        logic [7:0] wdata;
        logic [1:0] res;
        logic [3:0] lat;
        logic [15:0] rd_addr;
        logic [7:0] rd_exp;
    } fsp_row_t;

    logic clk, srst, icc_clk, icc_din, icc_dout, icc_oe, vpp, key_wr, req, rd, lvd_req, lvd_en;
    logic busy, done, rej, armed, prot, test_run;
    logic [7:0] key, wdata, rdata, tram_data, rd_val;
    logic [1:0] op, res;
    logic [15:0] addr, entry;
    logic [5:0] tram_addr;
    int lat;
    int err_count = 0;
    int n_tests = 0;
    // Arm: 0 none, 1 good keys, 2 bad second key
    fsp_row_t rows [11] = '{
        '{2'h1, 1'b1, FSP_OP_PROG, 16'he123, 8'h5a, 2'h2, 4'h1, 16'he123, 8'h5a},
        '{2'h1, 1'b1, FSP_OP_PROG, 16'hc010, 8'h3c, 2'h2, 4'h1, 16'hc010, 8'h3c},
        '{2'h1, 1'b1, FSP_OP_PROG, 16'hf000, 8'h11, 2'h1, 4'h1, 16'hf000, 8'hff},
        '{2'h0, 1'b1, FSP_OP_PROG, 16'he124, 8'h77, 2'h1, 4'h1, 16'he124, 8'hff},
        '{2'h2, 1'b1, FSP_OP_PROG, 16'he125, 8'h66, 2'h1, 4'h1, 16'he125, 8'hff},
        '{2'h1, 1'b1, FSP_OP_PROG, 16'hbfff, 8'h01, 2'h1, 4'h1, 16'hbfff, 8'hff},
        '{2'h1, 1'b0, FSP_OP_PROG, 16'he126, 8'h44, 2'h1, 4'h1, 16'he126, 8'hff},
        '{2'h1, 1'b1, FSP_OP_MASS, 16'he000, 8'h00, 2'h1, 4'h1, 16'he123, 8'h5a},
        '{2'h1, 1'b1, FSP_OP_SECT, 16'hf000, 8'h00, 2'h1, 4'h1, 16'hf000, 8'hff},
        '{2'h1, 1'b1, FSP_OP_SECT, 16'hc000, 8'h00, 2'h2, 4'h0, 16'he123, 8'h5a},
        '{2'h0, 1'b1, FSP_OP_PROG, 16'hc010, 8'h00, 2'h1, 4'h1, 16'hc010, 8'hff}
    };

    fsp_ctrl u_fsp_ctrl (
        .I_CLK(clk), .I_SRST(srst), .I_ICC_CLK(icc_clk), .I_ICC_DATA(icc_din), .O_ICC_DATA(icc_dout),
        .O_ICC_DATA_OE(icc_oe), .I_VPP_SEL(vpp), .I_CPU_KEY_WR(key_wr), .I_CPU_KEY(key), .I_CPU_REQ(req),
        .I_CPU_OP(op), .I_CPU_ADDR(addr), .I_CPU_WDATA(wdata), .I_CPU_RD(rd), .O_CPU_RDATA(rdata),
        .O_BUSY(busy), .O_DONE(done), .O_REJECT(rej), .O_GUARD_ARMED(armed), .O_PROTECTED(prot),
        .I_LVD_REQ(lvd_req), .O_LVD_EN(lvd_en), .I_TRAM_ADDR(tram_addr), .O_TRAM_DATA(tram_data),
        .O_TEST_RUN(test_run), .O_TEST_ENTRY(entry)
    );
    fsp_tool_model u_fsp_tool_model (
        .i_dev_data(icc_dout), .i_dev_oe(icc_oe), .o_clk(icc_clk), .o_data(icc_din), .o_vpp(vpp)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic report_and_stop();
        $display("Comparisons %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop

    // Polls done/refused pulse once per cycle
    task automatic wait_end(input int bound, output logic [1:0] r, output int n);
        r = 2'h0;
        n = 0;
        while (r == 2'h0 && n < bound) begin
            n++;
            r = {done === 1'b1, rej === 1'b1};
            if (r == 2'h0) @(negedge clk);
        end
        if (r == 2'h0) begin
            err_count++;
            $display("BAD wait timed out");
            report_and_stop();
        end
    endtask : wait_end

    task automatic put_key(input logic [7:0] k);
        key = k;
        key_wr = 1'b1;
        @(negedge clk);
        key_wr = 1'b0;
        @(negedge clk);
    endtask : put_key

    task automatic cpu_op(input logic [1:0] o, input logic [15:0] a, input logic [7:0] d,
                          output logic [1:0] r, output int n);
        op = o;
        addr = a;
        wdata = d;
        req = 1'b1;
        @(negedge clk);
        req = 1'b0;
        wait_end(20000, r, n);
        @(negedge clk);
    endtask : cpu_op

    task automatic cpu_read(input logic [15:0] a, output logic [7:0] d);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        d = rdata;
        rd = 1'b0;
    endtask : cpu_read

    task automatic link_op(input logic [7:0] c, input logic [15:0] a, input logic [7:0] d, output logic [1:0] r);
        int n;
        fork
            u_fsp_tool_model.send_frame(c, a, d, 1'b0);
            wait_end(40000, r, n);
        join
        @(negedge clk);
    endtask : link_op

    task automatic link_read(input logic [15:0] a, output logic [7:0] b);
        u_fsp_tool_model.send_frame(FSP_CMD_READ, a, 8'h00, 1'b1);
        u_fsp_tool_model.get_reply(b);
        @(negedge clk);
    endtask : link_read

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        // Bench owns reset while the tool is attached
        srst = 1'b1;
        {key_wr, req, rd, key, op, addr, wdata, tram_addr} = '0;
        lvd_req = 1'b1;
        repeat (4) @(posedge clk);
        @(negedge clk);
        srst = 1'b0;
        check("reset outputs", {busy, done, rej, armed, icc_oe, test_run, entry}, 24'h0);
        u_fsp_tool_model.set_vpp(1'b1);
        repeat (4) @(negedge clk);
        link_op(FSP_CMD_OPT, 16'h0000, 8'h00, res);
        check("unprotect", {res, prot, lvd_en}, {2'h2, 1'b0, 1'b1});
        link_op(FSP_CMD_MASS, 16'h0000, 8'h00, res);
        check("mass erase", res, 2'h2);
        $display("setup test ended");
        foreach (rows[i]) begin
            u_fsp_tool_model.set_vpp(rows[i].sup);
            repeat (4) @(negedge clk);
            if (rows[i].arm != 2'h0) put_key(`FSP_KEY1);
            if (rows[i].arm != 2'h0) put_key(rows[i].arm == 2'h1 ? `FSP_KEY2 : 8'h12);
            check("guard", armed, rows[i].arm == 2'h1);
            cpu_op(rows[i].op, rows[i].addr, rows[i].wdata, res, lat);
            check("cpu result", res, rows[i].res);
            if (rows[i].lat != 4'h0) check("cpu latency", lat[23:0], rows[i].lat);
            check("guard cleared", armed, 1'b0);
            cpu_read(rows[i].rd_addr, rd_val);
            check("readback", rd_val, rows[i].rd_exp);
            $display("row %0d test ended", i);
        end
        link_op(FSP_CMD_PROG, 16'hf000, 8'ha5, res);
        check("link program", res, 2'h2);
        link_read(16'hf000, rd_val);
        check("link read", {rd_val, icc_oe}, {8'ha5, 1'b0});
        link_op(FSP_CMD_SECT, 16'hf000, 8'h00, res);
        cpu_read(16'hf000, rd_val);
        check("link sector erase", {res, rd_val}, {2'h2, 8'hff});
        u_fsp_tool_model.send_frame(FSP_CMD_TRAM, 16'h0005, 8'h3c, 1'b0);
        tram_addr = 6'h05;
        repeat (10) @(negedge clk);
        check("test ram", tram_data, 8'h3c);
        fork
            u_fsp_tool_model.send_frame(FSP_CMD_EXEC, 16'h8010, 8'h00, 1'b0);
            for (int k = 0; k < 400 && test_run !== 1'b1; k++) @(negedge clk);
        join_any
        if (test_run !== 1'b1) begin
            err_count++;
            $display("BAD exec wait timed out");
            report_and_stop();
        end
        check("test start", {test_run, entry}, {1'b1, 16'h8010});
        wait fork;
        $display("link test ended");
        link_op(FSP_CMD_OPT, 16'h0000, 8'h01, res);
        check("protect", {res, prot, lvd_en}, {2'h2, 1'b1, 1'b0});
        link_read(16'he123, rd_val);
        check("protected link read", rd_val, 8'h00);
        put_key(`FSP_KEY1);
        put_key(`FSP_KEY2);
        cpu_op(FSP_OP_PROG, 16'he130, 8'h22, res, lat);
        check("protected cpu write", res, 2'h1);
        link_op(FSP_CMD_PROG, 16'he130, 8'h22, res);
        cpu_read(16'he123, rd_val);
        check("protected link write", {res, rd_val}, {2'h1, 8'h5a});
        link_op(FSP_CMD_OPT, 16'h0000, 8'h00, res);
        cpu_read(16'he123, rd_val);
        check("unprotect erases", {res, prot, lvd_en, rd_val}, {2'h2, 1'b0, 1'b1, 8'hff});
        lvd_req = 1'b0;
        @(negedge clk);
        check("supervisor request off", lvd_en, 1'b0);
        $display("protection test ended");
        report_and_stop();
    end
endmodule : fsp_ctrl_test
`default_nettype wire
